/* File: verilog/zat_top.sv */
// Local design decisions: the plain strobed port and the register offsets.
module zat_top
  import zat_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = SEC_CYCLES
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic [7:0] I_ZONE_IN,
  input wire logic [7:0] I_ZONE_BTN,
  input wire logic [7:0] I_TROUBLE,
  input wire logic I_MASTER_ARM,
  input wire logic I_ACK,
  input wire logic I_RESET_BTN,
  input wire logic I_LAMP_TEST,
  output logic [7:0] O_RED_LED,
  output logic [7:0] O_GREEN_LED,
  output logic [7:0] O_YELLOW_LED,
  output logic O_SOUNDER,
  output logic O_COMMON_TIMED,
  output logic [7:0] O_ZONE_OUT,
  output logic O_IRQ
);
  typedef struct packed {
    logic [27:0] sy1;
    logic [27:0] sy2;
    logic [27:0] sy3;
    logic [31:0] pre;
    logic flash;
    logic [2:0] ptr;
    logic [2:0] slot;
    logic [NZ-1:0] zarm;
    logic [NZ-1:0] pend;
    logic [NZ-1:0] rstp;
    logic [NZ-1:0] acked;
    logic [NZ-1:0] olat;
    zat_zone_t [NZ-1:0] zst;
    logic [NZ-1:0][7:0] tmr;
    logic ct_on;
    logic [5:0] ct_sec;
    logic [3:0] ct_min;
    logic [2:0] lstep;
    logic [7:0] ctrl;
    logic [15:0] ist;
    logic [15:0] ien;
    logic [23:0] loopt;
    logic [23:0] order;
    logic [63:0] bridge;
    logic [31:0] rdata;
    logic rmem;
    logic [7:0] red;
    logic [7:0] grn;
    logic [7:0] yel;
    logic [7:0] zout;
    logic snd;
    logic com;
  } zat_st_t;

  function automatic zat_st_t rst_val();
    zat_st_t r;
    r = '0;
    r.ctrl = CTRL_RST;
    r.order = ORDER_RST;
    r.bridge = BRIDGE_RST;
    return r;
  endfunction

  function automatic logic cfg_hit(input logic [7:0] a);
    return a[7:5] == A_CFG[7:5];
  endfunction

  // a setting of zero minutes would wrap round and run for sixteen, so it runs as one
  function automatic logic [3:0] tmins(input logic [7:0] c);
    return (c[C_MIN +: 4] == 4'h0) ? 4'h1 : c[C_MIN +: 4];
  endfunction

  localparam zat_st_t ST_RST = rst_val();

  zat_st_t s_q;
  zat_st_t n;
  logic [27:0] pins;
  logic [27:0] rise;
  logic sec_tick;
  logic half_tick;
  logic mst;
  logic lamp;
  logic [2:0] z;
  logic [31:0] cfg;
  logic [31:0] mem_rd;
  logic [7:0] tz;
  logic [7:0] al;
  logic [7:0] act;
  logic [7:0] lmask;
  logic [2:0] lz;
  logic arm;
  logic zin;
  logic expired;
  logic to_arm;
  logic to_alarm;

  assign pins = {I_LAMP_TEST, I_RESET_BTN, I_ACK, I_MASTER_ARM,
                 I_TROUBLE, I_ZONE_BTN, I_ZONE_IN};

  zat_cfg_mem u_mem (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_we(I_WR && cfg_hit(I_ADDR)),
    .i_waddr(I_ADDR[4:2]),
    .i_wdata(I_WDATA),
    .i_raddr_a(I_ADDR[4:2]),
    .o_rdata_a(mem_rd),
    .i_raddr_b(s_q.ptr),
    .o_rdata_b(cfg)
  );

  always_comb begin
    n = s_q;
    to_arm = 1'b0;
    to_alarm = 1'b0;
    n.sy1 = pins;
    n.sy2 = s_q.sy1;
    n.sy3 = s_q.sy2;
    rise = s_q.sy2 & ~s_q.sy3;
    mst = s_q.sy2[P_MARM];
    lamp = s_q.sy2[P_LAMP];
    for (int i = 0; i < NZ; i++) begin
      al[i] = (s_q.zst[i] == Z_ALARM);
      act[i] = al[i] & (s_q.olat[i] | s_q.sy2[P_ZIN + i]);
    end
    // seconds prescaler; flash phase flips every half second
    sec_tick = (s_q.pre == CYC_PER_SEC - 32'd1);
    half_tick = (s_q.pre == CYC_PER_SEC / 32'd2 - 32'd1);
    n.pre = sec_tick ? 32'h0 : s_q.pre + 32'd1;
    if (sec_tick || half_tick) begin
      n.flash = ~s_q.flash;
    end
    // bus slave; clear applies before this cycle's events so sets win
    n.rdata = '0;
    n.rmem = 1'b0;
    if (I_WR) begin
      case (I_ADDR)
        A_CTRL: n.ctrl = I_WDATA[7:0];
        A_ICLR: n.ist = s_q.ist & ~I_WDATA[15:0];
        A_IEN: n.ien = I_WDATA[15:0];
        A_LOOP: n.loopt = I_WDATA[23:0];
        A_ORDER: n.order = I_WDATA[23:0];
        A_BRLO: n.bridge[31:0] = I_WDATA;
        A_BRHI: n.bridge[63:32] = I_WDATA;
        default: ;
      endcase
    end
    if (I_RD) begin
      if (cfg_hit(I_ADDR)) begin
        n.rmem = 1'b1;
      end else begin
        case (I_ADDR)
          A_CTRL: n.rdata = {24'h0, s_q.ctrl};
          A_STAT: n.rdata = {16'h0, s_q.ist};
          A_IEN: n.rdata = {16'h0, s_q.ien};
          A_ZST: n.rdata = {14'h0, s_q.com, s_q.snd,
                            s_q.zarm & {NZ{mst}}, al};
          A_LOOP: n.rdata = {8'h0, s_q.loopt};
          A_ORDER: n.rdata = {8'h0, s_q.order};
          A_BRLO: n.rdata = s_q.bridge[31:0];
          A_BRHI: n.rdata = s_q.bridge[63:32];
          default: n.rdata = '0;
        endcase
      end
    end
    // arming controls
    n.zarm = s_q.zarm ^ rise[P_ZBTN +: NZ];
    if (rise[P_MARM]) begin
      n.zarm = '1;
    end
    if (rise[P_ACK]) begin
      n.acked = '1;
    end
    // common timed output countdown, one minute per sixty second ticks
    if (s_q.ct_on && sec_tick) begin
      if (s_q.ct_sec == MIN_SEC_LAST) begin
        n.ct_sec = 6'h0;
        n.ct_min = s_q.ct_min - 4'h1;
        if (s_q.ct_min == 4'h1) begin
          n.ct_on = 1'b0;
        end
      end else begin
        n.ct_sec = s_q.ct_sec + 6'h01;
      end
    end
    // zone scan: one zone per cycle, config arrives a cycle after ptr
    n.ptr = s_q.ptr + 3'h1;
    n.slot = s_q.ptr;
    z = s_q.slot;
    zin = s_q.sy2[P_ZIN + z];
    arm = mst & (s_q.zarm[z] | cfg[F_H24]);
    tz = s_q.tmr[z];
    if (s_q.pend[z] && tz != 8'h00) begin
      tz = s_q.tmr[z] - 8'h01;
    end
    expired = (tz == 8'h00);
    n.tmr[z] = tz;
    n.pend[z] = 1'b0;
    n.rstp[z] = 1'b0;
    n.olat[z] = (cfg[F_OTYPE +: 3] != OT_NONLATCH);
    unique case (s_q.zst[z])
      Z_IDLE: begin
        if (arm) begin
          to_arm = 1'b1;
        end else if (mst && zin) begin
          if (s_q.ctrl[C_PROP] && cfg[F_PROP +: 8] != 8'h00) begin
            n.zst[z] = Z_PROP;
            n.tmr[z] = cfg[F_PROP +: 8];
            n.pend[z] = 1'b0;
          end else begin
            to_alarm = 1'b1;
          end
        end
      end
      Z_PROP: begin
        if (arm) begin
          to_arm = 1'b1;
        end else if (!mst || !zin) begin
          n.zst[z] = Z_IDLE;
        end else if (expired) begin
          to_alarm = 1'b1;
        end
      end
      Z_EXIT: begin
        if (!arm) begin
          n.zst[z] = Z_IDLE;
        end else if (expired) begin
          n.zst[z] = Z_WATCH;
        end
      end
      Z_WATCH: begin
        if (!arm) begin
          n.zst[z] = Z_IDLE;
        end else if (zin) begin
          if (cfg[F_ENTRY +: 8] != 8'h00) begin
            n.zst[z] = Z_ENTRY;
            n.tmr[z] = cfg[F_ENTRY +: 8];
            n.pend[z] = 1'b0;
          end else begin
            to_alarm = 1'b1;
          end
        end
      end
      Z_ENTRY: begin
        if (!arm) begin
          n.zst[z] = Z_IDLE;
        end else if (expired) begin
          to_alarm = 1'b1;
        end
      end
      Z_ALARM: begin
        // reset only clears a zone whose loop has restored
        if (s_q.rstp[z] && !zin) begin
          n.zst[z] = arm ? Z_WATCH : Z_IDLE;
        end
      end
      default: n.zst[z] = Z_IDLE;
    endcase
    if (to_arm) begin
      if (cfg[F_EXIT +: 8] != 8'h00) begin
        n.zst[z] = Z_EXIT;
        n.tmr[z] = cfg[F_EXIT +: 8];
        n.pend[z] = 1'b0;
      end else begin
        n.zst[z] = Z_WATCH;
      end
    end
    if (to_alarm) begin
      n.zst[z] = Z_ALARM;
      n.acked[z] = 1'b0;
      n.ist[z] = 1'b1;
      n.ct_on = 1'b1;
      n.ct_sec = 6'h0;
      n.ct_min = tmins(s_q.ctrl);
    end
    if (sec_tick) begin
      n.pend = '1;
    end
    if (rise[P_RSTB]) begin
      n.rstp = '1;
    end
    n.ist[15:8] = n.ist[15:8] | rise[P_TRB +: NZ];
    // lamp test sequencer, one zone per second in programmed order
    if (!lamp) begin
      n.lstep = 3'h0;
    end else if (sec_tick && s_q.ctrl[C_SEQ]) begin
      n.lstep = s_q.lstep + 3'h1;
    end
    lz = s_q.order[3 * s_q.lstep +: 3];
    lmask = s_q.ctrl[C_SEQ] ? (8'h01 << lz) : 8'hff;
    // registered outputs
    n.red = lamp ? lmask : al & (s_q.acked | {NZ{s_q.flash}});
    n.grn = lamp ? lmask : s_q.sy2[P_ZIN +: NZ];
    n.yel = lamp ? lmask : ~(s_q.zarm & {NZ{mst}});
    n.snd = lamp | ((|(al & ~s_q.acked)) &
                    (~s_q.ctrl[C_PULSE] | s_q.flash));
    n.com = s_q.ctrl[C_TIMED] ? s_q.ct_on : |al;
    n.zout = '0;
    for (int i = 0; i < NZ; i++) begin
      for (int j = 0; j < NZ; j++) begin
        if (s_q.bridge[i * NZ + j] && act[i]) begin
          n.zout[j] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      s_q <= ST_RST;
    end else begin
      s_q <= n;
    end
  end

  assign O_RDATA = s_q.rmem ? mem_rd : s_q.rdata;
  assign O_RED_LED = s_q.red;
  assign O_GREEN_LED = s_q.grn;
  assign O_YELLOW_LED = s_q.yel;
  assign O_SOUNDER = s_q.snd;
  assign O_COMMON_TIMED = s_q.com;
  assign O_ZONE_OUT = s_q.zout;
  assign O_IRQ = |(s_q.ist & s_q.ien);
endmodule // zat_top

/* File: verilog/zat_pkg.sv */
package zat_pkg;
  localparam int NZ = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ICLR = 8'h08;
  localparam logic [7:0] A_IEN = 8'h0c;
  localparam logic [7:0] A_ZST = 8'h10;
  localparam logic [7:0] A_LOOP = 8'h14;
  localparam logic [7:0] A_ORDER = 8'h18;
  localparam logic [7:0] A_BRLO = 8'h1c;
  localparam logic [7:0] A_BRHI = 8'h20;
  localparam logic [7:0] A_CFG = 8'h40;
  localparam int C_PULSE = 0;
  localparam int C_PROP = 1;
  localparam int C_TIMED = 2;
  localparam int C_SEQ = 3;
  localparam int C_MIN = 4;
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam int F_ENTRY = 0;
  localparam int F_EXIT = 8;
  localparam int F_PROP = 16;
  localparam int F_OMIN = 24;
  localparam int F_OTYPE = 28;
  localparam int F_H24 = 31;
  localparam logic [2:0] OT_NONLATCH = 3'h1;
  localparam logic [23:0] ORDER_RST = 24'hfac688;
  localparam logic [63:0] BRIDGE_RST = 64'h8040201008040201;
  localparam int P_ZIN = 0;
  localparam int P_ZBTN = 8;
  localparam int P_TRB = 16;
  localparam int P_MARM = 24;
  localparam int P_ACK = 25;
  localparam int P_RSTB = 26;
  localparam int P_LAMP = 27;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  localparam int SEC_PER_MIN = 60;
  localparam logic [5:0] MIN_SEC_LAST = 6'(SEC_PER_MIN - 1);
  typedef enum logic [2:0] {
    Z_IDLE = 3'h0,
    Z_PROP = 3'h1,
    Z_EXIT = 3'h2,
    Z_WATCH = 3'h3,
    Z_ENTRY = 3'h4,
    Z_ALARM = 3'h5
  } zat_zone_t;
endpackage

/* File: verilog/zat_cfg_mem.sv */
module zat_cfg_mem
  import zat_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [2:0] i_raddr_a,
  output logic [31:0] o_rdata_a,
  input wire logic [2:0] i_raddr_b,
  output logic [31:0] o_rdata_b
);
  typedef struct packed {
    logic [NZ-1:0][31:0] mem;
    logic [31:0] ra;
    logic [31:0] rb;
  } zat_mem_st_t;
  zat_mem_st_t m_q;
  zat_mem_st_t m_d;

  // port b feeds the zone scan, port a the bus readback
  always_comb begin
    m_d = m_q;
    if (i_we) begin
      m_d.mem[i_waddr] = i_wdata;
    end
    m_d.ra = m_q.mem[i_raddr_a];
    m_d.rb = m_q.mem[i_raddr_b];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign o_rdata_a = m_q.ra;
  assign o_rdata_b = m_q.rb;
endmodule // zat_cfg_mem

/* File: test/zat_checker.sv */
module zat_checker
  import zat_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic [7:0] I_ZONE_IN,
  input wire logic [7:0] I_ZONE_BTN,
  input wire logic I_MASTER_ARM,
  input wire logic I_ACK,
  input wire logic I_RESET_BTN,
  input wire logic I_LAMP_TEST,
  input wire logic [7:0] O_RED_LED,
  input wire logic [7:0] O_GREEN_LED,
  input wire logic [7:0] O_YELLOW_LED,
  input wire logic O_SOUNDER,
  input wire logic O_COMMON_TIMED
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  logic [7:0] ctrl_q;
  logic [31:0] brlo_q;
  logic [31:0] cfg_q [8];
  logic [5:0] calm_q;
  logic [5:0] hush_q;
  logic calm_ev;
  logic hush_ev;
  // mirrors of written registers let readback be judged without the body
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_q <= CTRL_RST;
      brlo_q <= BRIDGE_RST[31:0];
      cfg_q <= '{default: 32'h0};
      calm_q <= 6'h0;
      hush_q <= 6'h0;
    end else begin
      if (I_WR && I_ADDR == A_CTRL) ctrl_q <= I_WDATA[7:0];
      if (I_WR && I_ADDR == A_BRLO) brlo_q <= I_WDATA;
      if (I_WR && I_ADDR[7:5] == 3'h2 && I_ADDR[1:0] == 2'h0)
        cfg_q[I_ADDR[4:2]] <= I_WDATA;
      calm_q <= calm_ev ? 6'h0 : calm_q + 6'(calm_q != 6'h3f);
      hush_q <= hush_ev ? 6'h0 : hush_q + 6'(hush_q != 6'h3f);
    end
  end
  always_comb begin
    calm_ev = I_WR || I_LAMP_TEST || I_ZONE_IN != 8'h0 || I_ZONE_BTN != 8'h0;
    hush_ev = I_WR || I_ACK || I_RESET_BTN || I_LAMP_TEST;
  end
  a_read_idle: assert property (
    !$past(I_RD) |-> O_RDATA == 32'h0) else $error("stray read data");
  a_ctrl_back: assert property (
    $past(I_RD) && $past(I_ADDR) == A_CTRL |-> O_RDATA == {24'h0, ctrl_q})
    else $error("control readback differs");
  a_bridge_back: assert property (
    $past(I_RD) && $past(I_ADDR) == A_BRLO |-> O_RDATA == brlo_q)
    else $error("bridge readback differs");
  a_cfg_back: assert property (
    $past(I_RD) && $past(I_ADDR[7:5]) == 3'h2 && $past(I_ADDR[1:0]) == 2'h0
    |-> O_RDATA == cfg_q[$past(I_ADDR[4:2])])
    else $error("zone config readback differs");
  a_unit_off: assert property (
    (!I_MASTER_ARM && !I_LAMP_TEST) [*5] |-> O_YELLOW_LED == 8'hff)
    else $error("zone armed with master off");
  a_lamp_all: assert property (
    (I_LAMP_TEST && !ctrl_q[C_SEQ]) [*6] |-> O_RED_LED == 8'hff
    && O_GREEN_LED == 8'hff && O_YELLOW_LED == 8'hff && O_SOUNDER)
    else $error("lamp test left an indicator dark");
  // a delay expiring inside the window would legally re-sound it
  a_ack_quiet: assert property (
    $rose(I_ACK) ##24 (calm_q > 6'h1e) |-> !O_SOUNDER)
    else $error("sounder still on after acknowledge");
  a_tone_steady: assert property (
    $fell(O_SOUNDER) |-> ctrl_q[C_PULSE] || hush_q < 6'h18)
    else $error("sounder broke without pulsing option");
  c_lamp_seq: cover property (I_LAMP_TEST && O_RED_LED == 8'h01);
  c_timed_off: cover property ($fell(O_COMMON_TIMED));
  c_pulse: cover property (ctrl_q[C_PULSE] && $fell(O_SOUNDER));
endmodule // zat_checker

bind zat_top zat_checker zat_checker_inst (.*);

/* File: test/zat_loop_model.sv */
module zat_loop_model (
  input wire logic i_clk,
  output logic [7:0] o_loop
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_loop = 8'h00;
  // momentary fault: loop opens for n cycles, then restores
  task automatic fault(int z, int n);
    o_loop[z] <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_loop[z] <= 1'b0;
  endtask
  task automatic hold(int z, bit v);
    o_loop[z] <= v;
  endtask
endmodule // zat_loop_model

/* File: test/test_zat_top.sv */
module test_zat_top
  import zat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CPS = 40;
  localparam logic [39:0] IRQ = 40'h80_0000_0000;
  localparam logic [39:0] SND = 40'h40_0000_0000;
  localparam logic [39:0] TMO = 40'h20_0000_0000;
  typedef struct {logic [39:0] v; logic [39:0] m;} zat_exp_t;
  logic clk, rst, wr, rd, marm, ack, rbtn, lamp, snd, tmo, irq;
  logic rd_q = 1'b0;
  logic pk = 1'b0;
  logic [7:0] addr, zbtn, trb, red, grn, yel, zout, zin;
  logic [31:0] wdat, rdat;
  int miscompares = 0;
  int check_count = 0;
  zat_exp_t exq[$];
  zat_exp_t e;
  wire [39:0] snap = {irq, snd, tmo, 5'h0, grn, zout, yel, red};
  zat_top #(.CYC_PER_SEC(CPS)) zat_top_inst (.I_CLOCK(clk), .I_RST(rst),
    .I_ADDR(addr), .I_WDATA(wdat), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat),
    .I_ZONE_IN(zin), .I_ZONE_BTN(zbtn), .I_TROUBLE(trb),
    .I_MASTER_ARM(marm), .I_ACK(ack), .I_RESET_BTN(rbtn),
    .I_LAMP_TEST(lamp), .O_RED_LED(red), .O_GREEN_LED(grn),
    .O_YELLOW_LED(yel), .O_SOUNDER(snd), .O_COMMON_TIMED(tmo),
    .O_ZONE_OUT(zout), .O_IRQ(irq));
  zat_loop_model zat_loop_model_inst (.i_clk(clk), .o_loop(zin));
  task automatic complete_run();
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(logic [39:0] seen, logic [39:0] want, logic [39:0] m);
    check_count++;
    if ((seen & m) !== (want & m)) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen & m, want & m);
    end
  endtask
  // the answer stands one cycle only, so it is taken at that edge
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q || pk) begin
      e = exq.pop_front();
      chk(rd_q ? {8'h0, rdat} : snap, e.v, e.m);
    end
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd_reg(logic [7:0] a, logic [39:0] v, logic [39:0] m);
    exq.push_back('{v, m});
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
  endtask
  task automatic look(logic [39:0] v, logic [39:0] m);
    exq.push_back('{v, m});
    pk <= 1'b1;
    cyc(1);
    pk <= 1'b0;
    cyc(1);
  endtask
  task automatic until_out(logic [39:0] v, logic [39:0] m, int n);
    int i;
    for (i = 0; i < n && (snap & m) !== (v & m); i++) cyc(1);
    if (i == n) begin
      miscompares++;
      complete_run();
    end
    look(v, m);
  endtask
  task automatic btn(int z);
    zbtn[z] <= 1'b1;
    cyc(4);
    zbtn[z] <= 1'b0;
    cyc(12);
  endtask
  task automatic ack_reset();
    ack <= 1'b1;
    cyc(4);
    ack <= 1'b0;
    rbtn <= 1'b1;
    cyc(4);
    rbtn <= 1'b0;
    cyc(20);
    wr_reg(A_ICLR, 32'hffff);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    int z;
    logic [31:0] r;
    {rst, wr, rd, marm, ack, rbtn, lamp} = 7'h40;
    {addr, zbtn, trb, wdat} = 56'h0;
    void'($urandom(89924));
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    rd_reg(A_CTRL, 40'h10, '1);
    rd_reg(A_ORDER, 40'hfac688, '1);
    rd_reg(A_BRHI, 40'h80402010, '1);
    rd_reg(8'hfc, 40'h0, '1);
    look(40'hff00, '1);
    for (z = 0; z < 8; z++) begin
      r = $urandom();
      wr_reg(A_CFG + 8'(4 * z), r);
      rd_reg(A_CFG + 8'(4 * z), {8'h0, r}, '1);
      wr_reg(A_CFG + 8'(4 * z), 32'h0);
    end
    wr_reg(A_BRLO, $urandom());
    wr_reg(A_BRLO, 32'h6);
    rd_reg(A_BRLO, 40'h6, '1);
    wr_reg(A_IEN, 32'h800);
    trb[3] <= 1'b1;
    until_out(IRQ, IRQ, 20);
    rd_reg(A_STAT, 40'h800, 40'hffff);
    wr_reg(A_IEN, 32'h0);
    look(40'h0, IRQ);
    wr_reg(A_ICLR, 32'h800);
    rd_reg(A_STAT, 40'h0, 40'hffff);
    trb[3] <= 1'b0;
    wr_reg(A_CFG, 32'h30000);
    wr_reg(A_CTRL, 32'h16);
    marm <= 1'b1;
    cyc(8);
    look(40'h0, 40'hff00);
    // master rise arms every zone; disarm them all for the prop test
    zbtn <= 8'hff;
    cyc(4);
    zbtn <= 8'h00;
    cyc(12);
    zat_loop_model_inst.fault(0, CPS);
    cyc(CPS * 4);
    rd_reg(A_STAT, 40'h0, 40'hff);
    zat_loop_model_inst.hold(0, 1'b1);
    cyc(CPS * 3 / 2);
    rd_reg(A_STAT, 40'h0, 40'hff);
    until_out(SND | TMO | 40'h60000, SND | TMO | 40'hff0000,
              CPS * 3);
    look(40'h1000000, 40'h1000000);
    wr_reg(A_CTRL, 32'h17);
    until_out(40'h0, SND, CPS);
    until_out(SND, SND, CPS);
    wr_reg(A_CTRL, 32'h16);
    until_out(40'h0, 40'h1, CPS);
    until_out(40'h1, 40'h1, CPS);
    ack <= 1'b1;
    cyc(4);
    ack <= 1'b0;
    until_out(40'h0, SND, 30);
    repeat (4) begin
      cyc(CPS / 4);
      look(40'h1, 40'h1);
    end
    cyc(CPS * 50);
    look(TMO, TMO);
    until_out(40'h0, TMO, CPS * 15);
    zat_loop_model_inst.hold(0, 1'b0);
    cyc(8);
    ack_reset();
    look(40'h0, 40'hff0001);
    wr_reg(A_CFG + 8'h4, 32'h204);
    btn(1);
    until_out(40'h0, 40'h200, 20);
    zat_loop_model_inst.fault(1, CPS / 2);
    rd_reg(A_STAT, 40'h0, 40'h2);
    cyc(CPS * 2);
    zat_loop_model_inst.hold(1, 1'b1);
    cyc(CPS / 2);
    zat_loop_model_inst.hold(1, 1'b0);
    rd_reg(A_STAT, 40'h0, 40'h2);
    btn(1);
    cyc(CPS * 5);
    rd_reg(A_STAT, 40'h0, 40'h2);
    btn(1);
    cyc(CPS * 3);
    zat_loop_model_inst.hold(1, 1'b1);
    until_out(SND, SND, CPS * 6);
    rd_reg(A_STAT, 40'h2, 40'h2);
    zat_loop_model_inst.hold(1, 1'b0);
    cyc(8);
    ack_reset();
    btn(1);
    wr_reg(A_CFG + 8'h8, 32'h50000);
    btn(2);
    zat_loop_model_inst.hold(2, 1'b1);
    until_out(SND, SND, 24);
    zat_loop_model_inst.hold(2, 1'b0);
    cyc(8);
    ack_reset();
    btn(2);
    marm <= 1'b0;
    cyc(8);
    zat_loop_model_inst.fault(4, CPS);
    cyc(8);
    rd_reg(A_STAT, 40'h0, 40'hff);
    look(40'hff00, 40'hff00);
    lamp <= 1'b1;
    until_out(40'h40ff00ffff, 40'h40ff00ffff, 20);
    lamp <= 1'b0;
    cyc(8);
    wr_reg(A_CTRL, 32'h1e);
    lamp <= 1'b1;
    until_out(40'h1, 40'hff, 20);
    until_out(40'h2, 40'hff, CPS * 2);
    lamp <= 1'b0;
    cyc(8);
    complete_run();
  end
endmodule // test_zat_top
